/* File: hw/tge_pkg.sv */
// Purpose: shared constants and types for the throttle and input-pin error status bank
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: duty measurement arrives as an 8-bit fraction of full scale (255 = 100%)
package tge_pkg;
   // register offsets on the management port
   localparam logic [7:0] PROC1_THROTTLE_ERROR_STATUS = 8'h44;
   localparam logic [7:0] PROC2_THROTTLE_ERROR_STATUS = 8'h45;
   localparam logic [7:0] INPUT_PIN_ERROR_STATUS = 8'h46;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // bit positions in a throttle status register
   localparam int BIT_ANY = 0;
   localparam int BIT_B0 = 1;
   localparam int BIT_B12 = 2;
   localparam int BIT_B25 = 3;
   localparam int BIT_B50 = 4;
   localparam int BIT_B75 = 5;
   localparam int BIT_FULL = 6;
   localparam int BIT_LIMIT = 7;
   // duty thresholds on the 0..255 scale (12.5%, 25%, 50%, 75%)
   localparam logic [7:0] DUTY_12 = 8'h20;
   localparam logic [7:0] DUTY_25 = 8'h40;
   localparam logic [7:0] DUTY_50 = 8'h80;
   localparam logic [7:0] DUTY_75 = 8'hC0;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   // sleep state codes as written to the sleep-state control register
   typedef enum logic [1:0] {TGE_S0, TGE_S1, TGE_S3, TGE_S45} tge_sleep_t;
   // one finished duty measurement for a processor
   typedef struct packed {
      logic valid;
      logic [7:0] duty;
      logic overLimit;
   } tge_meas_t;
endpackage

/* File: hw/tge_status_bank.sv */
// Purpose: sticky error bits for two throttle inputs and eight general input pins
// Assumes: duty measurements and pin levels synchronous to mclk
// Notes on behaviour
// (R1) any nonzero throttling sets bit 0 of that processor's status.
// (R2) duty from 0 up to below 12.5% sets bit 1.
// (R3) duty from 12.5% up to below 25% sets bit 2.
// (R4) bit 3 for 25 to 50 percent, bit 4 for 50 to 75.
// (R5) duty from 75% up to below 100% sets bit 5.
// (R6) throttle asserted the whole measurement sets bit 6.
// (R7) throttling over the user limit sets bit 7.
// (R8) only bit 7 of each throttle register feeds the summary error.
// (R9) input pin n low sets pin error bit n unless masked.
// (R10) no bit is set while in a sleep state that masks it.
// (R11) optional sleep masking of pin bits follows the sleep mask setting.
// (R12) bits stay set until written one; set beats clear.
`timescale 1ns/10ps
`default_nettype none
module tge_status_bank (
   input wire logic mclk,
   input wire logic rstn,
   input wire tge_pkg::tge_meas_t cpu1Meas,
   input wire tge_pkg::tge_meas_t cpu2Meas,
   input wire logic [7:0] generalPin,
   input wire logic [7:0] pinErrMask,
   input wire tge_pkg::tge_sleep_t sleepState,
   input wire logic [7:0] pinSleepMask,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic mgmtSummaryErr
);
   logic [7:0] proc1Status;
   logic [7:0] proc2Status;
   logic [7:0] pinStatus;

   // every throttle bit masks in S3 and S4/5
   wire throttleAsleep = (sleepState == tge_pkg::TGE_S3) ||
                         (sleepState == tge_pkg::TGE_S45); // R10
   // pin bits are only optionally masked in S1, S3, S4/5
   wire pinSleepy = sleepState != tge_pkg::TGE_S0;
   wire [7:0] pinSleepGate = pinSleepy ? pinSleepMask : 8'h00; // R11

   // band decode, a function since both processors share it
   function automatic logic [7:0] bandBits(input tge_pkg::tge_meas_t m);
      logic [7:0] b;
      b = 8'h00;
      if (m.valid) begin
         b[tge_pkg::BIT_ANY] = m.duty != 8'h00; // R1
         b[tge_pkg::BIT_B0] = m.duty < tge_pkg::DUTY_12; // R2
         b[tge_pkg::BIT_B12] = (m.duty >= tge_pkg::DUTY_12) &&
                               (m.duty < tge_pkg::DUTY_25); // R3
         b[tge_pkg::BIT_B25] = (m.duty >= tge_pkg::DUTY_25) &&
                               (m.duty < tge_pkg::DUTY_50); // R4
         b[tge_pkg::BIT_B50] = (m.duty >= tge_pkg::DUTY_50) &&
                               (m.duty < tge_pkg::DUTY_75); // R4
         b[tge_pkg::BIT_B75] = (m.duty >= tge_pkg::DUTY_75) &&
                               (m.duty < tge_pkg::DUTY_FULL); // R5
         b[tge_pkg::BIT_FULL] = m.duty == tge_pkg::DUTY_FULL; // R6
         b[tge_pkg::BIT_LIMIT] = m.overLimit; // R7
      end
      return b;
   endfunction

   // set terms after sleep gating
   wire [7:0] set1 = throttleAsleep ? 8'h00 : bandBits(cpu1Meas); // R10
   wire [7:0] set2 = throttleAsleep ? 8'h00 : bandBits(cpu2Meas); // R10
   wire [7:0] setPin = ~generalPin & ~pinErrMask & ~pinSleepGate; // R9

   // register selects, shared by the clear strobes and the read mux
   wire sel1 = regAddr == tge_pkg::PROC1_THROTTLE_ERROR_STATUS;
   wire sel2 = regAddr == tge_pkg::PROC2_THROTTLE_ERROR_STATUS;
   wire selPin = regAddr == tge_pkg::INPUT_PIN_ERROR_STATUS;

   // write-one-to-clear strobes per register
   wire [7:0] clr1 = (regWrite && sel1) ? regWdata : 8'h00; // R12
   wire [7:0] clr2 = (regWrite && sel2) ? regWdata : 8'h00; // R12
   wire [7:0] clrPin = (regWrite && selPin) ? regWdata : 8'h00; // R12

   // next values: a live condition keeps the bit set through a clear
   wire [7:0] next_proc1Status = set1 | (proc1Status & ~clr1); // R12
   wire [7:0] next_proc2Status = set2 | (proc2Status & ~clr2); // R12
   wire [7:0] next_pinStatus = setPin | (pinStatus & ~clrPin); // R12
   // summary looks at the limit bits and every pin bit; band bits are informational
   wire next_summary = next_proc1Status[tge_pkg::BIT_LIMIT] |
                       next_proc2Status[tge_pkg::BIT_LIMIT] | (|next_pinStatus); // R8

   // read mux; unmapped offsets read zero, last word holds between reads
   wire [7:0] next_regRdata =
      !regRead ? regRdata :
      sel1 ? proc1Status :
      sel2 ? proc2Status :
      selPin ? pinStatus : 8'h00;

   // status registers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         proc1Status <= tge_pkg::STATUS_RESET;
         proc2Status <= tge_pkg::STATUS_RESET;
         pinStatus <= tge_pkg::STATUS_RESET;
      end else begin
         proc1Status <= next_proc1Status;
         proc2Status <= next_proc2Status;
         pinStatus <= next_pinStatus;
      end
   end

   // outputs, registered
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         regRdata <= 8'h00;
         mgmtSummaryErr <= 1'b0;
      end else begin
         regRdata <= next_regRdata;
         mgmtSummaryErr <= next_summary;
      end
   end

   // any-throttle flag: nonzero duty sets it, zero duty never does
   a_any_throttle: assert property (@(posedge mclk) disable iff (!rstn) // R1
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty != 8'h00
      |=> proc2Status[tge_pkg::BIT_ANY])
      else $error("any-throttle bit missed");
   a_any_cpu1: assert property (@(posedge mclk) disable iff (!rstn) // R1
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty != 8'h00
      |=> proc1Status[tge_pkg::BIT_ANY])
      else $error("any-throttle bit missed on first processor");
   a_low_excl_any: assert property (@(posedge mclk) disable iff (!rstn) // R1
      cpu1Meas.valid && cpu1Meas.duty == 8'h00 && !proc1Status[tge_pkg::BIT_ANY]
      |=> !proc1Status[tge_pkg::BIT_ANY])
      else $error("any-throttle bit set by zero duty");

   // duty bands; each band has a lower bound that is inclusive, so the
   // threshold value itself must land in the upper band
   a_low_band: assert property (@(posedge mclk) disable iff (!rstn) // R2
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty < tge_pkg::DUTY_12
      |=> proc1Status[tge_pkg::BIT_B0])
      else $error("lowest band missed");
   a_low_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R2
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty < tge_pkg::DUTY_12
      |=> proc2Status[tge_pkg::BIT_B0])
      else $error("lowest band missed on second processor");
   a_band_12: assert property (@(posedge mclk) disable iff (!rstn) // R3
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty == tge_pkg::DUTY_12
      |=> proc1Status[tge_pkg::BIT_B12])
      else $error("12.5 band missed");
   a_b12_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R3
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty >= tge_pkg::DUTY_12 &&
      cpu2Meas.duty < tge_pkg::DUTY_25 |=> proc2Status[tge_pkg::BIT_B12])
      else $error("12.5 band missed on second processor");
   a_b25_cpu1: assert property (@(posedge mclk) disable iff (!rstn) // R4
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty >= tge_pkg::DUTY_25 &&
      cpu1Meas.duty < tge_pkg::DUTY_50 |=> proc1Status[tge_pkg::BIT_B25])
      else $error("25 band missed");
   a_b25_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R4
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty >= tge_pkg::DUTY_25 &&
      cpu2Meas.duty < tge_pkg::DUTY_50 |=> proc2Status[tge_pkg::BIT_B25])
      else $error("25 band missed on second processor");
   a_band_50: assert property (@(posedge mclk) disable iff (!rstn) // R4
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty == tge_pkg::DUTY_50
      |=> proc2Status[tge_pkg::BIT_B50])
      else $error("50 band wrong");
   a_b50_cpu1: assert property (@(posedge mclk) disable iff (!rstn) // R4
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty >= tge_pkg::DUTY_50 &&
      cpu1Meas.duty < tge_pkg::DUTY_75 |=> proc1Status[tge_pkg::BIT_B50])
      else $error("50 band missed on first processor");
   a_band_75: assert property (@(posedge mclk) disable iff (!rstn) // R5
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty == tge_pkg::DUTY_75
      |=> proc1Status[tge_pkg::BIT_B75])
      else $error("75 band missed");
   a_b75_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R5
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty >= tge_pkg::DUTY_75 &&
      cpu2Meas.duty < tge_pkg::DUTY_FULL |=> proc2Status[tge_pkg::BIT_B75])
      else $error("75 band missed on second processor");
   a_full_excl_75: assert property (@(posedge mclk) disable iff (!rstn) // R5
      cpu1Meas.valid && cpu1Meas.duty == tge_pkg::DUTY_FULL &&
      !proc1Status[tge_pkg::BIT_B75] |=> !proc1Status[tge_pkg::BIT_B75])
      else $error("full duty leaked into 75 band");

   // full throttle has its own bit, apart from the top band
   a_band_sets: assert property (@(posedge mclk) disable iff (!rstn) // R6
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.duty == tge_pkg::DUTY_FULL
      |=> proc1Status[tge_pkg::BIT_FULL])
      else $error("full throttle bit not set");
   a_full_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R6
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.duty == tge_pkg::DUTY_FULL
      |=> proc2Status[tge_pkg::BIT_FULL])
      else $error("full throttle bit not set on second processor");

   // limit bits and the summary; summary is built from next values, so it
   // rises in the same cycle as the bit and a clear right after cannot race it
   a_limit_set: assert property (@(posedge mclk) disable iff (!rstn) // R7
      !throttleAsleep && cpu1Meas.valid && cpu1Meas.overLimit
      |=> proc1Status[tge_pkg::BIT_LIMIT] && mgmtSummaryErr)
      else $error("limit error not raised");
   a_limit_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R7
      !throttleAsleep && cpu2Meas.valid && cpu2Meas.overLimit
      |=> proc2Status[tge_pkg::BIT_LIMIT] && mgmtSummaryErr)
      else $error("limit error not raised on second processor");
   a_summary_src: assert property (@(posedge mclk) disable iff (!rstn) // R8
      !next_proc1Status[tge_pkg::BIT_LIMIT] && !next_proc2Status[tge_pkg::BIT_LIMIT] &&
      next_pinStatus == 8'h00 |=> !mgmtSummaryErr)
      else $error("summary driven by band bits");
   a_summary_lim2: assert property (@(posedge mclk) disable iff (!rstn) // R8
      next_proc2Status[tge_pkg::BIT_LIMIT]
      |=> mgmtSummaryErr)
      else $error("summary missed second limit bit");

   // input pins, low is the error level
   a_pin_low: assert property (@(posedge mclk) disable iff (!rstn) // R9
      !generalPin[0] && !pinErrMask[0] && !pinSleepGate[0]
      |=> pinStatus[0])
      else $error("pin error missed");
   a_pin_low7: assert property (@(posedge mclk) disable iff (!rstn) // R9
      !generalPin[7] && !pinErrMask[7] && !pinSleepGate[7]
      |=> pinStatus[7])
      else $error("top pin error missed");
   a_pin_mask: assert property (@(posedge mclk) disable iff (!rstn) // R9
      pinErrMask[0] && !pinStatus[0]
      |=> !pinStatus[0])
      else $error("masked pin error set");
   a_pin_high: assert property (@(posedge mclk) disable iff (!rstn) // R9
      generalPin[7] && !pinStatus[7]
      |=> !pinStatus[7])
      else $error("pin error set while pin high");

   // sleep gating: throttle bits always masked in deep sleep, pins only
   // where the optional mask bit asks for it
   a_sleep_mask: assert property (@(posedge mclk) disable iff (!rstn) // R10
      sleepState == tge_pkg::TGE_S3 && proc1Status == 8'h00 && !regWrite
      |=> proc1Status == 8'h00)
      else $error("set during sleep");
   a_sleep_s3_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R10
      sleepState == tge_pkg::TGE_S3 && proc2Status == 8'h00
      |=> proc2Status == 8'h00)
      else $error("second processor set during sleep");
   a_sleep45_cpu2: assert property (@(posedge mclk) disable iff (!rstn) // R10
      sleepState == tge_pkg::TGE_S45 && proc2Status == 8'h00
      |=> proc2Status == 8'h00)
      else $error("second processor set in deepest sleep");
   a_opt_mask: assert property (@(posedge mclk) disable iff (!rstn) // R11
      pinSleepy && pinSleepMask[3] && !pinStatus[3]
      |=> !pinStatus[3])
      else $error("optional sleep mask ignored");
   a_s0_no_gate: assert property (@(posedge mclk) disable iff (!rstn) // R11
      sleepState == tge_pkg::TGE_S0 && !generalPin[3] && !pinErrMask[3]
      |=> pinStatus[3])
      else $error("sleep mask applied while awake");
   a_opt_unmasked: assert property (@(posedge mclk) disable iff (!rstn) // R11
      pinSleepy && !pinSleepMask[3] && !generalPin[3] && !pinErrMask[3]
      |=> pinStatus[3])
      else $error("pin masked in sleep without mask bit");

   // sticky bits and write-one-to-clear, set wins a tie
   a_sticky_hold: assert property (@(posedge mclk) disable iff (!rstn) // R12
      pinStatus[5] && !(regWrite && selPin && regWdata[5])
      |=> pinStatus[5])
      else $error("bit cleared without write");
   a_sticky_p1: assert property (@(posedge mclk) disable iff (!rstn) // R12
      proc1Status[7] && !(regWrite && sel1 && regWdata[7])
      |=> proc1Status[7])
      else $error("limit bit cleared without write");
   a_sticky_p2: assert property (@(posedge mclk) disable iff (!rstn) // R12
      proc2Status[0] && !(regWrite && sel2 && regWdata[0])
      |=> proc2Status[0])
      else $error("any-throttle bit cleared without write");
   a_clear_works: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regWrite && selPin && regWdata[2] && generalPin[2]
      |=> !pinStatus[2])
      else $error("pin error not cleared");
   a_set_wins: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regWrite && selPin && regWdata[1] && !generalPin[1] && !pinErrMask[1] &&
      !pinSleepGate[1] |=> pinStatus[1])
      else $error("clear beat a live pin error");
   a_clear_p1: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regWrite && sel1 && regWdata[7] && !cpu1Meas.valid
      |=> !proc1Status[7])
      else $error("limit bit not cleared");

   // read port: one cycle latency, data held between reads
   a_read_p1: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regRead && sel1
      |=> regRdata == $past(proc1Status))
      else $error("first throttle register read wrong");
   a_read_p2: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regRead && sel2
      |=> regRdata == $past(proc2Status))
      else $error("second throttle register read wrong");
   a_read_pin: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regRead && selPin
      |=> regRdata == $past(pinStatus))
      else $error("pin register read wrong");
   a_read_unmapped: assert property (@(posedge mclk) disable iff (!rstn) // R12
      regRead && !sel1 && !sel2 && !selPin
      |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (@(posedge mclk) disable iff (!rstn) // R12
      !regRead
      |=> $stable(regRdata))
      else $error("read data moved without a read");
endmodule
`default_nettype wire

/* File: dv/tge_cpu_model.sv */
// Purpose: processor throttle source driving one measurement port
// Assumes: fire is a one-cycle request from the bench
// Notes: idle fields are scrambled so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module tge_cpu_model (
   input wire logic mclk,
   input wire logic fire,
   input wire logic [7:0] duty,
   input wire logic over,
   output tge_pkg::tge_meas_t meas
);
   initial meas = '0;
   // one valid cycle per request, inverted junk between requests
   always @(posedge mclk) begin
      meas.valid <= fire;
      meas.duty <= fire ? duty : ~meas.duty;
      meas.overLimit <= fire ? over : ~meas.overLimit;
   end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: self-checking bench for the status bank
// Assumes: read result one cycle after the read edge
// Notes: driver queues {summary, data}; watcher compares
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk = 0, rstn = 0, fire = 0, o1 = 0, o2 = 0, pend = 0;
   logic regWrite = 0, regRead = 0, mgmtSummaryErr;
   logic [7:0] d1 = 0, d2 = 0, generalPin = 8'hFF, pinErrMask = 0, pinSleepMask = 0;
   logic [7:0] regAddr = 0, regWdata = 0, regRdata, v, w, s, e;
   tge_pkg::tge_sleep_t sleepState = tge_pkg::TGE_S0;
   tge_pkg::tge_meas_t m1, m2;
   logic [8:0] q[$];
   logic [8:0] x;
   logic [31:0] lf = 32'h0000_58ab;
   logic [7:0] tbl [12] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h3F, 8'h40, 8'h7F, 8'h80,
      8'hBF, 8'hC0, 8'hFE, 8'hFF};
   int err_total = 0, num_checks = 0, cyc = 0;
   always #5 mclk = ~mclk;
   tge_cpu_model P1 (.mclk(mclk), .fire(fire), .duty(d1), .over(o1), .meas(m1));
   tge_cpu_model P2 (.mclk(mclk), .fire(fire), .duty(d2), .over(o2), .meas(m2));
   tge_status_bank DUT (.mclk(mclk), .rstn(rstn), .cpu1Meas(m1), .cpu2Meas(m2),
      .generalPin(generalPin), .pinErrMask(pinErrMask), .sleepState(sleepState),
      .pinSleepMask(pinSleepMask), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .mgmtSummaryErr(mgmtSummaryErr));
   function automatic logic [7:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction
   // expected bits from the duty bands, 0x20 per 12.5 percent
   function automatic logic [7:0] band(input logic [7:0] d, input logic o);
      return {o, d == 8'hFF, d >= 8'hC0 && d != 8'hFF, d >= 8'h80 && d < 8'hC0,
         d >= 8'h40 && d < 8'h80, d >= 8'h20 && d < 8'h40, d < 8'h20, d != 0};
   endfunction
   task automatic rd(input logic [7:0] a, input logic [8:0] ex);
      @(posedge mclk);
      regRead <= 1;
      regAddr <= a;
      q.push_back(ex);
      @(posedge mclk);
      regRead <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      @(posedge mclk);
      regWrite <= 1;
      regAddr <= a;
      regWdata <= dt;
      @(posedge mclk);
      regWrite <= 0;
   endtask
   task automatic fireBoth();
      @(posedge mclk);
      fire <= 1;
      @(posedge mclk);
      fire <= 0;
   endtask
   task automatic end_of_test();
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // watcher: read data settles in the cycle after the read edge
   always @(posedge mclk) pend <= regRead;
   always @(negedge mclk) if (pend) begin
      x = q.pop_front();
      num_checks++;
      if ({mgmtSummaryErr, regRdata} !== x) begin
         err_total++;
         $display("ERROR summary/regRdata exp %h got %h", x, {mgmtSummaryErr, regRdata});
      end
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge mclk) if (++cyc == 5000) begin
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1;
      rd(8'h44, 9'h000);
      for (int i = 0; i < 24; i++) begin
         v = i < 12 ? tbl[i] : rnd();
         w = rnd();
         d1 <= v;
         d2 <= w;
         o1 <= w[0];
         o2 <= w[1];
         fireBoth();
         rd(8'h44, {w[0] | w[1], band(v, w[0])});
         rd(8'h44, {w[0] | w[1], band(v, w[0])});
         rd(8'h45, {w[0] | w[1], band(w, w[1])});
         wr(8'h44, 8'hFF);
         wr(8'h45, 8'hFF);
      end
      sleepState <= tge_pkg::TGE_S3;
      d1 <= 8'hFF;
      o1 <= 1;
      o2 <= 1;
      fireBoth();
      rd(8'h44, 9'h000);
      rd(8'h45, 9'h000);
      for (int i = 0; i < 8; i++) begin
         v = rnd();
         w = rnd();
         s = rnd();
         e = ~v & ~w & (i[1:0] != 0 ? ~s : 8'hFF);
         sleepState <= tge_pkg::tge_sleep_t'(i[1:0]);
         generalPin <= v;
         pinErrMask <= w;
         pinSleepMask <= s;
         rd(8'h46, {|e, e});
         wr(8'h46, 8'hFF);
         rd(8'h46, {|e, e});
         generalPin <= 8'hFF;
         wr(8'h46, 8'hFF);
         rd(8'h46, 9'h000);
      end
      wr(8'h47, 8'hFF);
      rd(8'h47, 9'h000);
      repeat (2) @(posedge mclk);
      end_of_test();
   end
endmodule
`default_nettype wire
